// ---- src/iosd_addr_decode.sv ----
// Address decoder: turns a core request into an I/O location and its legality.
// Assumes the request is stable for the cycle it is presented.
`timescale 1ns/1ps
module iosd_addr_decode (
  input  iosd_pkg::iosd_req_s i_req,
  output logic [5:0]          o_idx,
  output logic                o_hit,
  output logic                o_usb_sel,
  output logic                o_bit_kind
);

  wire        is_mem   = (i_req.kind == iosd_pkg::IOSD_MEM_READ) ||
                         (i_req.kind == iosd_pkg::IOSD_MEM_WRITE);
  wire        bit_kind = (i_req.kind == iosd_pkg::IOSD_SET_IO_BIT_INSTR) ||
                         (i_req.kind == iosd_pkg::IOSD_CLEAR_IO_BIT_INSTR) ||
                         (i_req.kind == iosd_pkg::IOSD_SKIP_IF_IO_BIT_ONE) ||
                         (i_req.kind == iosd_pkg::IOSD_SKIP_IF_IO_BIT_ZERO);
  // Dedicated transfers carry a 6-bit address; upper bits must be clear
  wire        io_legal = (i_req.addr[15:6] == 10'h000); // RL4
  // Data-space alias sits at the I/O address plus the offset
  wire        mem_legal = (i_req.addr >= iosd_pkg::IOSD_DATA_ALIAS_OFS) &&
                          (i_req.addr <= iosd_pkg::IOSD_DATA_ALIAS_END); // RL5
  wire [15:0] mem_ofs  = i_req.addr - iosd_pkg::IOSD_DATA_ALIAS_OFS;
  wire [5:0]  idx      = is_mem ? mem_ofs[5:0] : i_req.addr[5:0];
  // Bit operations only reach the lower half of the space
  wire        bit_ok   = !bit_kind || (idx <= iosd_pkg::IOSD_BIT_RANGE_TOP); // RL2 RL3
  wire        legal    = is_mem ? mem_legal : io_legal;

  // USB hardware sits only in its own data page, never in I/O space
  assign o_usb_sel  = i_req.valid && is_mem &&
                      (i_req.addr[15:8] == iosd_pkg::IOSD_USB_PAGE); // RL6
  assign o_idx      = idx;
  assign o_bit_kind = bit_kind;
  assign o_hit      = i_req.valid && legal && bit_ok && iosd_pkg::IOSD_MAPPED_MASK[idx];

endmodule

// ---- src/iosd_io_space.sv ----
// I/O space register decoder: 64-location register bank reached by dedicated
// transfers, bit set/clear/test and the data-space alias.
// Assumes the core issues at most one request per clock and that the pins
// and flag-set inputs are synchronous to i_ref_clk.
`timescale 1ns/1ps

// Summary of operation
// RL1: Dedicated read and write move one byte between a working register and I/O.
// RL2: Set-bit and clear-bit alter only the chosen bit, addresses 0x00 to 0x1F.
// RL3: Skip-if-one and skip-if-zero test one chosen bit in that lower range.
// RL4: Dedicated transfers use a 6-bit I/O address, 0x00 to 0x3F.
// RL5: Data-memory accesses reach each I/O register at its address plus 0x20.
// RL6: Everything lives in I/O space except USB registers, in their data page.
// RL7: Software writes zero to reserved bits whenever it writes a register.
// RL8: Software never writes reserved or unassigned I/O addresses.
// RL9: External interrupt mask sits at 0x3B, external interrupt flags at 0x3A.
// RL10: Unassigned addresses read zero and disturb no other register.
module iosd_io_space (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_reset,
  input  iosd_pkg::iosd_req_s         i_req,
  input  iosd_pkg::iosd_pins_s        i_pins,
  input  wire logic [7:0]             i_ext_irq_set,
  output iosd_pkg::iosd_resp_s        o_resp,
  output iosd_pkg::iosd_wr_evt_s      o_wr_evt,
  output logic [7:0]                  o_ext_irq_mask,
  output logic [7:0]                  o_ext_irq_flags,
  output logic [7:0]                  o_core_status
);

  localparam int N = iosd_pkg::IOSD_IO_LOCATIONS;

  // Decoder outputs
  logic [5:0] idx;
  logic       hit;
  logic       usb_sel;
  logic       bit_kind;

  iosd_addr_decode u_decode (
    .i_req      (i_req),
    .o_idx      (idx),
    .o_hit      (hit),
    .o_usb_sel  (usb_sel),
    .o_bit_kind (bit_kind)
  );

  // Register bank, one byte per I/O location
  logic [7:0] mem_q [N];
  logic [7:0] mem_d [N];

  iosd_pkg::iosd_resp_s   resp_q;
  iosd_pkg::iosd_resp_s   resp_d;
  iosd_pkg::iosd_wr_evt_s wr_evt_q;
  iosd_pkg::iosd_wr_evt_s wr_evt_d;

  // Kind classification
  wire is_read  = (i_req.kind == iosd_pkg::IOSD_IO_READ) ||
                  (i_req.kind == iosd_pkg::IOSD_MEM_READ);
  wire is_wbyte = (i_req.kind == iosd_pkg::IOSD_IO_WRITE) ||
                  (i_req.kind == iosd_pkg::IOSD_MEM_WRITE);
  wire is_set   = (i_req.kind == iosd_pkg::IOSD_SET_IO_BIT_INSTR);
  wire is_clr   = (i_req.kind == iosd_pkg::IOSD_CLEAR_IO_BIT_INSTR);
  wire is_sk1   = (i_req.kind == iosd_pkg::IOSD_SKIP_IF_IO_BIT_ONE);
  wire is_sk0   = (i_req.kind == iosd_pkg::IOSD_SKIP_IF_IO_BIT_ZERO);

  // The interrupt pair keeps only its top two bits; the rest read zero
  wire        is_irq_reg = (idx == iosd_pkg::IOSD_EXT_IRQ_MASK) ||
                           (idx == iosd_pkg::IOSD_EXT_IRQ_FLAGS); // RL9
  wire [7:0]  read_mask  = is_irq_reg ? iosd_pkg::IOSD_EXT_IRQ_BITS
                                      : iosd_pkg::IOSD_FULL_BYTE;
  wire [7:0]  cur_byte   = mem_q[idx] & read_mask;
  wire [7:0]  bit_onehot = 8'h01 << i_req.bit_sel;
  wire        cur_bit    = cur_byte[i_req.bit_sel];

  // Byte written back: whole byte for transfers, one bit changed for bit ops
  wire [7:0]  wr_byte    = is_wbyte ? i_req.wdata :                        // RL1
                           is_set   ? (cur_byte | bit_onehot) :            // RL2
                                      (cur_byte & ~bit_onehot);            // RL2
  wire        wr_kind    = is_wbyte || is_set || is_clr;
  // Unassigned and pin locations never take a write
  wire        wr_en      = hit && wr_kind && !iosd_pkg::IOSD_PIN_MASK[idx]; // RL10

  // Flag register: software clears by writing ones; bit ops stop at 0x1F and never reach it.
  // A clear-bit instruction would rewrite the other flags as ones, so it is
  // treated as touching nothing; this avoids wiping pending requests.
  wire        flag_wr    = wr_en && (idx == iosd_pkg::IOSD_EXT_IRQ_FLAGS); // RL9
  wire [7:0]  flag_clr   = !flag_wr ? 8'h00 :
                           is_wbyte ? i_req.wdata :
                           is_set   ? bit_onehot : 8'h00;

  // Per-location next value; only assigned locations hold state
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_loc
      localparam logic [5:0] LOC = 6'(g);
      if (!iosd_pkg::IOSD_MAPPED_MASK[g]) begin : g_hole
        assign mem_d[g] = iosd_pkg::IOSD_RESET_BYTE; // RL10
      end else if (LOC == iosd_pkg::IOSD_PORT_A_INPUT) begin : g_pa
        assign mem_d[g] = i_pins.port_a;
      end else if (LOC == iosd_pkg::IOSD_PORT_B_INPUT) begin : g_pb
        assign mem_d[g] = i_pins.port_b;
      end else if (LOC == iosd_pkg::IOSD_PORT_D_INPUT) begin : g_pd
        assign mem_d[g] = i_pins.port_d;
      end else if (LOC == iosd_pkg::IOSD_EXT_IRQ_FLAGS) begin : g_flg
        // Set wins over a clear arriving in the same cycle
        assign mem_d[g] = ((mem_q[g] & ~flag_clr) | i_ext_irq_set) &
                          iosd_pkg::IOSD_EXT_IRQ_BITS; // RL9
      end else if (LOC == iosd_pkg::IOSD_EXT_IRQ_MASK) begin : g_msk
        assign mem_d[g] = (wr_en && idx == LOC) ?
                          (wr_byte & iosd_pkg::IOSD_EXT_IRQ_BITS) : mem_q[g]; // RL9
      end else begin : g_reg
        assign mem_d[g] = (wr_en && idx == LOC) ? wr_byte : mem_q[g]; // RL1 RL2
      end
    end
  endgenerate

  // Answer: read data, skip decision, USB pointer and refusal
  wire skip_now = hit && ((is_sk1 && cur_bit) || (is_sk0 && !cur_bit)); // RL3
  always_comb begin
    resp_d         = '0;
    resp_d.valid   = i_req.valid;
    resp_d.rdata   = (hit && is_read) ? cur_byte : iosd_pkg::IOSD_RESET_BYTE; // RL1 RL10
    resp_d.skip    = skip_now;
    resp_d.usb_sel = usb_sel; // RL6
    resp_d.err     = i_req.valid && !hit && !usb_sel;
  end

  // Write notice toward the peripherals, one cycle per accepted write
  always_comb begin
    wr_evt_d       = '0;
    wr_evt_d.valid = wr_en;
    wr_evt_d.idx   = idx;
    wr_evt_d.data  = flag_wr ? flag_clr : wr_byte;
  end

  // Bank state
  always_ff @(posedge i_ref_clk) begin
    for (int k = 0; k < N; k++) begin
      mem_q[k] <= i_reset ? iosd_pkg::IOSD_RESET_BYTE : mem_d[k];
    end
  end

  // Registered answers
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      resp_q   <= '0;
      wr_evt_q <= '0;
    end else begin
      resp_q   <= resp_d;
      wr_evt_q <= wr_evt_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_resp          = resp_q;
  assign o_wr_evt        = wr_evt_q;
  assign o_ext_irq_mask  = mem_q[iosd_pkg::IOSD_EXT_IRQ_MASK];
  assign o_ext_irq_flags = mem_q[iosd_pkg::IOSD_EXT_IRQ_FLAGS];
  assign o_core_status   = mem_q[iosd_pkg::IOSD_CORE_STATUS_FLAGS];

endmodule

// ---- src/iosd_pkg.sv ----
// Package for the I/O space register decoder: map, field masks and carriers.
// Assumes one core clock and a synchronous core reset shared with the CPU.
package iosd_pkg;

  // I/O addresses of the mapped registers (data space address is this plus alias offset)
  localparam logic [5:0] IOSD_UART_BAUD_DIVISOR     = 6'h09;
  localparam logic [5:0] IOSD_UART_CONTROL          = 6'h0A;
  localparam logic [5:0] IOSD_UART_STATUS           = 6'h0B;
  localparam logic [5:0] IOSD_PORT_D_INPUT          = 6'h10;
  localparam logic [5:0] IOSD_PORT_D_DIRECTION      = 6'h11;
  localparam logic [5:0] IOSD_PORT_D_OUTPUT         = 6'h12;
  localparam logic [5:0] IOSD_PORT_C_OUTPUT         = 6'h13;
  localparam logic [5:0] IOSD_PORT_B_INPUT          = 6'h16;
  localparam logic [5:0] IOSD_PORT_B_DIRECTION      = 6'h17;
  localparam logic [5:0] IOSD_PORT_B_OUTPUT         = 6'h18;
  localparam logic [5:0] IOSD_PORT_A_INPUT          = 6'h19;
  localparam logic [5:0] IOSD_PORT_A_DIRECTION      = 6'h1A;
  localparam logic [5:0] IOSD_PORT_A_OUTPUT         = 6'h1B;
  localparam logic [5:0] IOSD_WATCHDOG_CONTROL      = 6'h21;
  localparam logic [5:0] IOSD_CAPTURE_LOW_BYTE      = 6'h24;
  localparam logic [5:0] IOSD_CAPTURE_HIGH_BYTE     = 6'h25;
  localparam logic [5:0] IOSD_COMPARE_B_LOW_BYTE    = 6'h28;
  localparam logic [5:0] IOSD_COMPARE_B_HIGH_BYTE   = 6'h29;
  localparam logic [5:0] IOSD_COMPARE_A_LOW_BYTE    = 6'h2A;
  localparam logic [5:0] IOSD_COMPARE_A_HIGH_BYTE   = 6'h2B;
  localparam logic [5:0] IOSD_WIDE_TIMER_COUNT_LOW  = 6'h2C;
  localparam logic [5:0] IOSD_WIDE_TIMER_COUNT_HIGH = 6'h2D;
  localparam logic [5:0] IOSD_WIDE_TIMER_CONTROL_B  = 6'h2E;
  localparam logic [5:0] IOSD_WIDE_TIMER_CONTROL_A  = 6'h2F;
  localparam logic [5:0] IOSD_NARROW_TIMER_COUNT    = 6'h32;
  localparam logic [5:0] IOSD_NARROW_TIMER_CONTROL  = 6'h33;
  localparam logic [5:0] IOSD_CPU_GENERAL_CONTROL   = 6'h35;
  localparam logic [5:0] IOSD_TIMER_IRQ_FLAGS       = 6'h38;
  localparam logic [5:0] IOSD_TIMER_IRQ_MASK        = 6'h39;
  localparam logic [5:0] IOSD_EXT_IRQ_FLAGS         = 6'h3A;
  localparam logic [5:0] IOSD_EXT_IRQ_MASK          = 6'h3B;
  localparam logic [5:0] IOSD_STACK_POINTER_LOW     = 6'h3D;
  localparam logic [5:0] IOSD_STACK_POINTER_HIGH    = 6'h3E;
  localparam logic [5:0] IOSD_CORE_STATUS_FLAGS     = 6'h3F;

  // One bit per I/O location: set where a register is assigned
  localparam logic [63:0] IOSD_MAPPED_MASK   = 64'hEF2C_FF32_0FCF_0E00;
  // Pin input locations follow the pins and ignore writes
  localparam logic [63:0] IOSD_PIN_MASK      = 64'h0000_0000_0241_0000;

  // Space layout
  localparam int          IOSD_IO_LOCATIONS   = 64;
  localparam logic [5:0]  IOSD_BIT_RANGE_TOP  = 6'h1F;
  localparam logic [15:0] IOSD_DATA_ALIAS_OFS = 16'h0020;
  localparam logic [15:0] IOSD_DATA_ALIAS_END = 16'h005F;
  localparam logic [7:0]  IOSD_USB_PAGE       = 8'h1F;

  // Value after reset of every register, and implemented bits of the interrupt pair
  localparam logic [7:0]  IOSD_RESET_BYTE     = 8'h00;
  localparam logic [7:0]  IOSD_EXT_IRQ_BITS   = 8'hC0;
  localparam logic [7:0]  IOSD_FULL_BYTE      = 8'hFF;

  // Transfer kinds issued by the core
  typedef enum logic [2:0] {
    IOSD_IO_READ,
    IOSD_IO_WRITE,
    IOSD_SET_IO_BIT_INSTR,
    IOSD_CLEAR_IO_BIT_INSTR,
    IOSD_SKIP_IF_IO_BIT_ONE,
    IOSD_SKIP_IF_IO_BIT_ZERO,
    IOSD_MEM_READ,
    IOSD_MEM_WRITE
  } iosd_kind_e;

  typedef struct packed {
    logic        valid;
    iosd_kind_e  kind;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [2:0]  bit_sel;
  } iosd_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
    logic       skip;
    logic       usb_sel;
    logic       err;
  } iosd_resp_s;

  typedef struct packed {
    logic       valid;
    logic [5:0] idx;
    logic [7:0] data;
  } iosd_wr_evt_s;

  typedef struct packed {
    logic [7:0] port_a;
    logic [7:0] port_b;
    logic [7:0] port_d;
  } iosd_pins_s;

endpackage

// ---- tb/iosd_core_model.sv ----
// Core-side model: issues one request at a time and collects its answer.
// Assumes the decoder answers on the edge after taking the request.
`timescale 1ns/1ps
module iosd_core_model (
  input  wire logic            i_ref_clk,
  input  iosd_pkg::iosd_resp_s i_resp,
  output iosd_pkg::iosd_req_s  o_req
);
  initial o_req = '0;
  // Valid drops and address, data and bit select are inverted on release so stale values cannot look valid
  task automatic op(input iosd_pkg::iosd_kind_e k, input logic [15:0] a,
                    input logic [7:0] d, input logic [2:0] b,
                    output iosd_pkg::iosd_resp_s r);
    @(posedge i_ref_clk);
    #1 o_req = '{1'b1, k, a, d, b};
    @(posedge i_ref_clk);
    #1 r = i_resp;
    o_req = '{1'b0, k, ~a, ~d, ~b};
  endtask
endmodule

// ---- tb/iosd_io_space_asserts.sv ----
// Checker for the I/O space decoder, watching only its top-level ports.
// Assumes one request per clock, answered on the edge after it is taken.
`timescale 1ns/1ps
module iosd_io_space_asserts (
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset,
  input  iosd_pkg::iosd_req_s    i_req,
  input  iosd_pkg::iosd_pins_s   i_pins,
  input  wire logic [7:0]        i_ext_irq_set,
  input  iosd_pkg::iosd_resp_s   o_resp,
  input  iosd_pkg::iosd_wr_evt_s o_wr_evt,
  input  wire logic [7:0]        o_ext_irq_mask,
  input  wire logic [7:0]        o_ext_irq_flags,
  input  wire logic [7:0]        o_core_status
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Request decode; bit kinds are encodings 2 to 5, data-space kinds 6 and 7
  wire io_go = i_req.valid && i_req.addr[15:6] == 10'h000;
  wire is_wr = i_req.kind == iosd_pkg::IOSD_IO_WRITE;
  wire bit_k = i_req.kind[2:1] == 2'b01 || i_req.kind[2:1] == 2'b10;
  wire mem_k = i_req.kind[2:1] == 2'b11;
  sequence s_wr_status;
    io_go && is_wr && i_req.addr[5:0] == 6'h3F;
  endsequence
  sequence s_wr_mask;
    io_go && is_wr && i_req.addr[5:0] == 6'h3B;
  endsequence
  AST_ANSWER: assert property (i_req.valid |=> o_resp.valid)
    else $error("request not answered");
  AST_QUIET: assert property (!i_req.valid |=> !o_resp.valid && !o_wr_evt.valid)
    else $error("answer without request");
  AST_STATUS_WR: assert property (s_wr_status |=> o_wr_evt.valid
    && o_core_status == $past(i_req.wdata)) else $error("status write lost");
  AST_MASK_WR: assert property (s_wr_mask |=>
    o_ext_irq_mask == ($past(i_req.wdata) & 8'hC0)) else $error("mask write wrong");
  AST_IRQ_BITS: assert property (((o_ext_irq_mask | o_ext_irq_flags) & 8'h3F) == 8'h00)
    else $error("unimplemented irq bit set");
  AST_BIT_RANGE: assert property (i_req.valid && bit_k && i_req.addr > 16'h001F
    |=> o_resp.err) else $error("bit op above range accepted");
  AST_UNMAPPED: assert property (io_go && !is_wr && !bit_k && !mem_k
    && !iosd_pkg::IOSD_MAPPED_MASK[i_req.addr[5:0]] |=> o_resp.rdata == 8'h00 && o_resp.err)
    else $error("unassigned read not zero");
  AST_ALIAS: assert property (i_req.valid && i_req.kind == iosd_pkg::IOSD_MEM_READ
    && i_req.addr == 16'h005F |=> o_resp.rdata == o_core_status && !o_resp.err)
    else $error("alias read wrong");
  AST_USB: assert property (i_req.valid && mem_k && i_req.addr[15:8] == 8'h1F
    |=> o_resp.usb_sel && !o_resp.err) else $error("usb page not routed");
endmodule
bind iosd_io_space iosd_io_space_asserts u_chk (.i_ref_clk, .i_reset, .i_req, .i_pins,
  .i_ext_irq_set, .o_resp, .o_wr_evt, .o_ext_irq_mask, .o_ext_irq_flags, .o_core_status);

// ---- tb/tb.sv ----
// Testbench for the I/O space decoder; the core model issues all requests.
// Assumes a 10 MHz core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch %0t %h vs %h", $time, a, b); end end
module tb;
  localparam iosd_pkg::iosd_kind_e RD = iosd_pkg::IOSD_IO_READ;
  localparam iosd_pkg::iosd_kind_e WR = iosd_pkg::IOSD_IO_WRITE;
  logic                   ref_clk, reset;
  logic [7:0]             irq_set, mask, flags, status, v;
  int                     n_errors, checks_done, cyc;
  iosd_pkg::iosd_req_s    req;
  iosd_pkg::iosd_resp_s   resp, r;
  iosd_pkg::iosd_pins_s   pins;
  iosd_pkg::iosd_wr_evt_s evt;
  iosd_io_space dut (.i_ref_clk(ref_clk), .i_reset(reset), .i_req(req), .i_pins(pins),
    .i_ext_irq_set(irq_set), .o_resp(resp), .o_wr_evt(evt), .o_ext_irq_mask(mask),
    .o_ext_irq_flags(flags), .o_core_status(status));
  iosd_core_model core (.i_ref_clk(ref_clk), .i_resp(resp), .o_req(req));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Hang guard: the scenarios need well under a few hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic io(iosd_pkg::iosd_kind_e k, logic [15:0] a, logic [7:0] d = 8'h00,
                    logic [2:0] b = 3'h0);
    core.op(k, a, d, b, r);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Byte write, read back and data-space alias over registers in both halves
  task automatic t_rw();
    t_rw_one(6'h09);
    t_rw_one(6'h13);
    t_rw_one(6'h2F);
    t_rw_one(6'h3E);
    t_rw_one(6'h3F);
  endtask
  task automatic t_rw_one(logic [5:0] a);
    v = 8'hA5 ^ {2'b00, a};
    io(WR, {10'h000, a}, v);
    `CHK(evt.idx, a)
    `CHK(evt.data, v)
    io(RD, {10'h000, a});
    `CHK(r.rdata, v)
    io(iosd_pkg::IOSD_MEM_READ, {10'h000, a} + 16'h0020);
    `CHK(r.rdata, v)
  endtask
  // Bit set, clear and both tests on port A output, then a bit op above range
  task automatic t_bits();
    io(WR, 16'h001B, 8'hA5);
    io(iosd_pkg::IOSD_SET_IO_BIT_INSTR, 16'h001B, 8'h00, 3'h3);
    io(iosd_pkg::IOSD_CLEAR_IO_BIT_INSTR, 16'h001B, 8'h00, 3'h0);
    io(RD, 16'h001B);
    `CHK(r.rdata, 8'hAC)
    io(iosd_pkg::IOSD_SKIP_IF_IO_BIT_ONE, 16'h001B, 8'h00, 3'h3);
    `CHK(r.skip, 1'b1)
    io(iosd_pkg::IOSD_SKIP_IF_IO_BIT_ZERO, 16'h001B, 8'h00, 3'h3);
    `CHK(r.skip, 1'b0)
    io(iosd_pkg::IOSD_SKIP_IF_IO_BIT_ZERO, 16'h001B, 8'h00, 3'h4);
    `CHK(r.skip, 1'b1)
    io(iosd_pkg::IOSD_SET_IO_BIT_INSTR, 16'h0021, 8'h00, 3'h0);
    `CHK(r.err, 1'b1)
  endtask
  // External interrupt pair: mask bits, flag set by pulse and write-one clear
  task automatic t_irq();
    io(WR, 16'h003B, 8'hC0);
    `CHK(mask, 8'hC0)
    @(posedge ref_clk);
    #1 irq_set = 8'h40;
    @(posedge ref_clk);
    #1 irq_set = 8'h00;
    io(RD, 16'h003A);
    `CHK(r.rdata, 8'h40)
    io(WR, 16'h003A, 8'h40);
    `CHK(flags, 8'h00)
  endtask
  // Refusals: unassigned place and wide address, then USB page routing, pins and status
  task automatic t_refuse();
    io(iosd_pkg::IOSD_MEM_WRITE, 16'h005F, 8'h3C);
    io(RD, 16'h0000);
    `CHK({r.err, r.rdata}, 9'h100)
    io(RD, 16'h0030);
    `CHK({r.err, evt.valid}, 2'b10)
    io(RD, 16'h0040);
    `CHK(r.err, 1'b1)
    io(iosd_pkg::IOSD_MEM_READ, 16'h1F10);
    `CHK({r.usb_sel, r.err}, 2'b10)
    io(RD, 16'h0019);
    `CHK(r.rdata, pins.port_a)
    `CHK(status, 8'h3C)
  endtask
  initial begin
    reset = 1'b1;
    irq_set = 8'h00;
    pins = '{8'h96, 8'h3C, 8'h0F};
    repeat (6) @(posedge ref_clk);
    #1 reset = 1'b0;
    io(RD, 16'h003F);
    `CHK(r.rdata, 8'h00)
    t_rw();
    t_bits();
    t_irq();
    t_refuse();
    test_done();
  end
endmodule
